// *** logic/fpet_flash_timing.v ***
// flash program and erase sequencer with axi4-lite register access
// Summary of operation
// - program array pulse is (psc+1)(prog+1) clocks
// - program array erase is (psc+1)*4*(erase+1)
// - program array start delay (psc+1)(start+1)
// - program array transition (psc+1)(tran+1)
// - program array end delay holds pump power
// - hold address two cycles before next
// - pump enable held one cycle past operation
// - data array pulse uses its own settings
// - data array erase uses its own settings
// - data array delays use its own settings
// - data reprogram cycle at least 1.32 ms; a shorter cycle is not blocked, it only sets the status flag
// - isp array uses data array timing
//
// The register offsets and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "fpet_regs.vh"
module fpet_flash_timing
(
  input  wire        core_clk,      // system clock, 100 MHz
  input  wire        sys_rst,       // synchronous reset, active high
  input  wire [7:0]  s_axi_awaddr,  // write address
  input  wire        s_axi_awvalid, // write address valid
  output wire        s_axi_awready, // write address ready
  input  wire [31:0] s_axi_wdata,   // write data
  input  wire [3:0]  s_axi_wstrb,   // write byte strobes
  input  wire        s_axi_wvalid,  // write data valid
  output wire        s_axi_wready,  // write data ready
  output reg  [1:0]  s_axi_bresp,   // write response
  output reg         s_axi_bvalid,  // write response valid
  input  wire        s_axi_bready,  // write response ready
  input  wire [7:0]  s_axi_araddr,  // read address
  input  wire        s_axi_arvalid, // read address valid
  output wire        s_axi_arready, // read address ready
  output reg  [31:0] s_axi_rdata,   // read data
  output reg  [1:0]  s_axi_rresp,   // read response
  output reg         s_axi_rvalid,  // read valid
  input  wire        s_axi_rready,  // read ready
  output reg         progArraySel,  // program array selected
  output reg         dataArraySel,  // data array selected
  output reg         ispArraySel,   // isp array selected
  output reg         pumpEnable,    // charge pump enable
  output reg         pumpPower,     // charge pump power
  output reg         progPulse,     // program high voltage pulse
  output reg         erasePulse,    // erase high voltage pulse
  output reg         addrLatch      // flash address may change
);
  // one-hot sequencer states
  localparam [7:0] ST_IDLE  = 8'h01;
  localparam [7:0] ST_START = 8'h02;
  localparam [7:0] ST_TRAN1 = 8'h04;
  localparam [7:0] ST_PULSE = 8'h08;
  localparam [7:0] ST_TRAN2 = 8'h10;
  localparam [7:0] ST_END   = 8'h20;
  localparam [7:0] ST_HOLD  = 8'h40;
  localparam [7:0] ST_ADDR  = 8'h80;

  reg  [31:0] progTiming_reg;  // program array psc/start/tran/end
  reg  [31:0] progPulse_reg;   // program array prog/erase counts
  reg  [31:0] dataTiming_reg;  // data array psc/start/tran/end
  reg  [31:0] dataPulse_reg;   // data array prog/erase counts
  reg  [7:0]  state_reg;       // sequencer state
  reg  [7:0]  state_next;      // next state
  reg         isErase_reg;     // operation is erase
  reg  [1:0]  arraySel_reg;    // array of the operation
  reg  [1:0]  holdCnt_reg;     // hold counter
  reg  [20:0] reprogCnt_reg;   // cycles since data erase began
  reg         reprogShort_reg; // data reprogram cycle too short
  reg  [2:0]  byteCnt_reg;     // data bytes programmed since erase
  reg         awSeen_reg;      // write address taken
  reg         wSeen_reg;       // write data taken
  reg  [7:0]  awAddr_reg;      // latched write address
  reg  [31:0] wData_reg;       // latched write data
  reg  [3:0]  wStrb_reg;       // latched write strobes
  reg         goPulse;         // start request from control write
  reg         phaseStart;      // load the phase timer
  reg  [17:0] phaseLen;        // count for the next phase
  wire        phaseDone;       // phase timer finished
  wire [31:0] selTiming;       // timing word of active array
  wire [31:0] selPulse;        // pulse word of active array
  wire        busy;            // sequencer not idle

  // merge strobed bytes into a register value
  function [31:0] mergeBytes;
    input [31:0] oldVal;
    input [31:0] newVal;
    input [3:0]  strb;
    integer i;
    begin
      mergeBytes = oldVal;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          mergeBytes[i*8 +: 8] = newVal[i*8 +: 8];
    end
  endfunction

  // a field of a timing word; used for start, tran and end
  function [17:0] field8;
    input [31:0] word;
    input [4:0]  lsb;
    begin
      field8 = {10'h000, word[lsb +: 8]};
    end
  endfunction

  // isp borrows the data array settings
  assign selTiming = (arraySel_reg == `FPET_SEL_PROG) ? progTiming_reg :
                     dataTiming_reg;
  assign selPulse  = (arraySel_reg == `FPET_SEL_PROG) ? progPulse_reg :
                     dataPulse_reg;
  assign busy      = (state_reg != ST_IDLE);

  fpet_phase_timer uPhase
  (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .startPulse (phaseStart),
    .prescale   (selTiming[`FPET_PSC_LSB +: 8]),
    .phaseCount (phaseLen),
    .phaseDone  (phaseDone)
  );

  // ready while the channel has not yet been taken; the write channels also wait while a write answer is pending
  assign s_axi_awready = !awSeen_reg && !s_axi_bvalid;
  assign s_axi_wready  = !wSeen_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // write path: address and data in either order, then response
  always @(posedge core_clk)
  begin
    goPulse <= 1'b0;
    if (sys_rst)
    begin
      awSeen_reg     <= 1'b0;
      wSeen_reg      <= 1'b0;
      awAddr_reg     <= 8'h00;
      wData_reg      <= 32'h00000000;
      wStrb_reg      <= 4'h0;
      s_axi_bvalid   <= 1'b0;
      s_axi_bresp    <= `FPET_RESP_OKAY;
      progTiming_reg <= `FPET_TIMING_RST;
      progPulse_reg  <= `FPET_PULSE_RST;
      dataTiming_reg <= `FPET_TIMING_RST;
      dataPulse_reg  <= `FPET_PULSE_RST;
      isErase_reg    <= 1'b0;
      arraySel_reg   <= `FPET_SEL_PROG;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awSeen_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wSeen_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      if (awSeen_reg && wSeen_reg)
      begin
        // both halves present: commit and answer
        awSeen_reg   <= 1'b0;
        wSeen_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `FPET_RESP_OKAY;
        case (awAddr_reg)
          `FPET_PROG_TIMING_ADDR:
            progTiming_reg <= mergeBytes(progTiming_reg, wData_reg,
                                         wStrb_reg);
          `FPET_PROG_PULSE_ADDR:
            progPulse_reg <= mergeBytes(progPulse_reg, wData_reg,
                                        wStrb_reg);
          `FPET_DATA_TIMING_ADDR:
            dataTiming_reg <= mergeBytes(dataTiming_reg, wData_reg,
                                         wStrb_reg);
          `FPET_DATA_PULSE_ADDR:
            dataPulse_reg <= mergeBytes(dataPulse_reg, wData_reg,
                                        wStrb_reg);
          `FPET_CONTROL_ADDR:
          begin
            // a start while busy is ignored; array and erase selection stay stable
            if (!busy && wStrb_reg[0] && wData_reg[`FPET_CTL_GO])
            begin
              goPulse      <= 1'b1;
              isErase_reg  <= wData_reg[`FPET_CTL_ERASE];
              arraySel_reg <= wData_reg[`FPET_CTL_ARRAY1:`FPET_CTL_ARRAY0];
            end
          end
          `FPET_STATUS_ADDR:
            s_axi_bresp <= `FPET_RESP_OKAY;
          default:
            s_axi_bresp <= `FPET_RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // read path: one cycle from address to data
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `FPET_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `FPET_RESP_OKAY;
      case (s_axi_araddr)
        `FPET_PROG_TIMING_ADDR: s_axi_rdata <= progTiming_reg;
        `FPET_PROG_PULSE_ADDR:  s_axi_rdata <= progPulse_reg;
        `FPET_DATA_TIMING_ADDR: s_axi_rdata <= dataTiming_reg;
        `FPET_DATA_PULSE_ADDR:  s_axi_rdata <= dataPulse_reg;
        `FPET_CONTROL_ADDR:
          s_axi_rdata <= {28'h0000000, arraySel_reg, isErase_reg, busy};
        `FPET_STATUS_ADDR:
          s_axi_rdata <= {21'h000000, reprogShort_reg, byteCnt_reg,
                          state_reg[6:0]};
        default:
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `FPET_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // next state and phase loads
  always @*
  begin
    state_next = state_reg;
    phaseStart = 1'b0;
    phaseLen   = 18'h00000;
    case (state_reg)
      ST_IDLE:
        if (goPulse)
        begin
          state_next = ST_START;
          phaseStart = 1'b1;
          phaseLen   = field8(selTiming, `FPET_START_LSB);
        end
      ST_START:
        if (phaseDone)
        begin
          state_next = ST_TRAN1;
          phaseStart = 1'b1;
          phaseLen   = field8(selTiming, `FPET_TRAN_LSB);
        end
      ST_TRAN1:
        if (phaseDone)
        begin
          state_next = ST_PULSE;
          phaseStart = 1'b1;
          if (isErase_reg)
            // four units per erase step: (erase+1)*4 - 1
            phaseLen = {selPulse[`FPET_ERASE_LSB +: 16], 2'b11};
          else
            phaseLen = {2'b00, selPulse[`FPET_PROG_LSB +: 16]};
        end
      ST_PULSE:
        if (phaseDone)
        begin
          state_next = ST_TRAN2;
          phaseStart = 1'b1;
          phaseLen   = field8(selTiming, `FPET_TRAN_LSB);
        end
      ST_TRAN2:
        if (phaseDone)
        begin
          state_next = ST_END;
          phaseStart = 1'b1;
          phaseLen   = field8(selTiming, `FPET_END_LSB);
        end
      ST_END:
        if (phaseDone)
          state_next = ST_HOLD;
      ST_HOLD:
        // pump enable stays up this extra cycle
        state_next = ST_ADDR;
      ST_ADDR:
        if (holdCnt_reg == `FPET_ADDR_HOLD_LAST)
          state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end

  // state register, hold counter and registered flash controls
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state_reg    <= ST_IDLE;
      holdCnt_reg  <= 2'h0;
      progArraySel <= 1'b0;
      dataArraySel <= 1'b0;
      ispArraySel  <= 1'b0;
      pumpEnable   <= 1'b0;
      pumpPower    <= 1'b0;
      progPulse    <= 1'b0;
      erasePulse   <= 1'b0;
      addrLatch    <= 1'b1;
    end
    else
    begin
      state_reg   <= state_next;
      holdCnt_reg <= (state_reg == ST_ADDR) ? holdCnt_reg + 2'h1 : 2'h0;
      progArraySel <= (state_next != ST_IDLE) &&
                      (arraySel_reg == `FPET_SEL_PROG);
      dataArraySel <= (state_next != ST_IDLE) &&
                      (arraySel_reg == `FPET_SEL_DATA);
      ispArraySel  <= (state_next != ST_IDLE) &&
                      (arraySel_reg == `FPET_SEL_ISP);
      // power held through end delay, enable one cycle longer
      pumpPower  <= (state_next != ST_IDLE) && (state_next != ST_HOLD) &&
                    (state_next != ST_ADDR);
      pumpEnable <= (state_next != ST_IDLE) &&
                    (state_next != ST_ADDR);
      progPulse  <= (state_next == ST_PULSE) && !isErase_reg;
      erasePulse <= (state_next == ST_PULSE) && isErase_reg;
      // address held from start until hold cycles are done
      addrLatch  <= (state_next == ST_IDLE);
    end
  end

  // data array reprogram cycle: erase then four bytes, timed
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      reprogCnt_reg   <= 21'h000000;
      byteCnt_reg     <= 3'h0;
      reprogShort_reg <= 1'b0;
    end
    else if (goPulse && arraySel_reg != `FPET_SEL_PROG && isErase_reg)
    begin
      reprogCnt_reg <= 21'h000000;
      byteCnt_reg   <= 3'h0;
    end
    else
    begin
      if (reprogCnt_reg != 21'h1FFFFF)
        reprogCnt_reg <= reprogCnt_reg + 21'h000001;
      if (goPulse && arraySel_reg != `FPET_SEL_PROG && byteCnt_reg != 3'h4)
        byteCnt_reg <= byteCnt_reg + 3'h1;
      // flag a fourth byte finishing before the minimum cycle time
      if (state_reg == ST_HOLD && byteCnt_reg == 3'h4 && !isErase_reg &&
          arraySel_reg != `FPET_SEL_PROG &&
          reprogCnt_reg < `FPET_REPROG_MIN)
        reprogShort_reg <= 1'b1;
    end
  end
endmodule // fpet_flash_timing
`default_nettype wire

// *** logic/fpet_phase_timer.v ***
// prescaled phase counter: runs (psc+1)*(count+1) clock cycles
`timescale 1ns/100ps
`default_nettype none
module fpet_phase_timer
(
  input  wire        core_clk,   // system clock
  input  wire        sys_rst,    // synchronous reset
  input  wire        startPulse, // load and start a phase
  input  wire [7:0]  prescale,   // prescaler value
  input  wire [17:0] phaseCount, // phase length in prescaled units - 1
  output wire        phaseDone   // one-cycle pulse at end of phase
);
  reg  [7:0]  pscCnt_reg;   // prescaler down counter
  reg  [17:0] unitCnt_reg;  // unit down counter
  reg         running_reg;  // phase active

  assign phaseDone = running_reg && (pscCnt_reg == 8'h00) &&
                     (unitCnt_reg == 18'h00000);

  // prescaled countdown; done is the last cycle of the phase
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      pscCnt_reg  <= 8'h00;
      unitCnt_reg <= 18'h00000;
      running_reg <= 1'b0;
    end
    else if (startPulse)
    begin
      pscCnt_reg  <= prescale;
      unitCnt_reg <= phaseCount;
      running_reg <= 1'b1;
    end
    else if (running_reg)
    begin
      if (phaseDone)
        running_reg <= 1'b0;
      else if (pscCnt_reg == 8'h00)
      begin
        // unit boundary, reload prescaler
        pscCnt_reg  <= prescale;
        unitCnt_reg <= unitCnt_reg - 18'h00001;
      end
      else
        pscCnt_reg <= pscCnt_reg - 8'h01;
    end
  end
endmodule // fpet_phase_timer
`default_nettype wire

// *** logic/fpet_regs.vh ***
// register offsets, field layout and timing constants of the flash timer
`ifndef FPET_REGS_VH
`define FPET_REGS_VH
// register byte offsets
`define FPET_PROG_TIMING_ADDR  8'h00
`define FPET_PROG_PULSE_ADDR   8'h04
`define FPET_DATA_TIMING_ADDR  8'h08
`define FPET_DATA_PULSE_ADDR   8'h0C
`define FPET_CONTROL_ADDR      8'h10
`define FPET_STATUS_ADDR       8'h14
// timing word fields: prescaler, start, transition, end
`define FPET_PSC_LSB    0
`define FPET_START_LSB  8
`define FPET_TRAN_LSB   16
`define FPET_END_LSB    24
// pulse word fields: program count, erase count
`define FPET_PROG_LSB   0
`define FPET_ERASE_LSB  16
// control fields
`define FPET_CTL_GO     0
`define FPET_CTL_ERASE  1
`define FPET_CTL_ARRAY0 2
`define FPET_CTL_ARRAY1 3
// array selector codes
`define FPET_SEL_PROG   2'h0
`define FPET_SEL_DATA   2'h1
`define FPET_SEL_ISP    2'h2
// reset values of the timing words
`define FPET_TIMING_RST 32'h00000000
`define FPET_PULSE_RST  32'h00000000
// erase pulse is four prescaled units per step, kept as a shift of two
`define FPET_ERASE_MULT 2
// address hold and enable hold, in clock cycles
`define FPET_ADDR_HOLD_CYC 2
`define FPET_PUMP_HOLD_CYC 1
// last value of the two-bit address hold counter
`define FPET_ADDR_HOLD_LAST 2'h1
// data array reprogramming cycle in ns and its minimum cycle count
`define FPET_REPROG_NS  1320000
`define FPET_CLK_NS     10
`define FPET_REPROG_CYC ((`FPET_REPROG_NS + `FPET_CLK_NS - 1) / `FPET_CLK_NS)
// the same minimum sized to the reprogram counter
`define FPET_REPROG_MIN 21'h203A0
// axi responses
`define FPET_RESP_OKAY   2'h0
`define FPET_RESP_SLVERR 2'h2
`endif

// *** sim/fpet_flash_model.sv ***
// flash array stand-in: times the high-voltage phases it is given
`timescale 1ns/100ps
`default_nettype none
module fpet_flash_model
(
  input  wire logic        core_clk,
  input  wire logic        pumpPower,
  input  wire logic        progPulse,
  input  wire logic        erasePulse,
  input  wire logic        dataArraySel,
  input  wire logic        ispArraySel,
  output var  logic        flashEvt,
  output var  logic [31:0] preLen,
  output var  logic [31:0] pulseLen,
  output var  logic [31:0] postLen,
  output var  logic [1:0]  selCode
);
  logic [1:0]  phase = 2'h0; // idle, lead, pulse, tail
  logic [31:0] cnt = 32'h0;  // cycles in current phase
  wire         hv = progPulse | erasePulse;
  // one event per operation, lengths hold until the next one
  always @(posedge core_clk)
  begin
    flashEvt <= 1'b0;
    cnt <= cnt + 32'h1;
    case (phase)
      2'h0:
        if (pumpPower)
        begin
          phase <= 2'h1;
          cnt <= 32'h1;
        end
      2'h1:
        if (hv)
        begin
          preLen <= cnt;
          selCode <= dataArraySel ? 2'h1 : (ispArraySel ? 2'h2 : 2'h0);
          phase <= 2'h2;
          cnt <= 32'h1;
        end
      2'h2:
        if (!hv)
        begin
          pulseLen <= cnt;
          phase <= 2'h3;
          cnt <= 32'h1;
        end
      default:
        if (!pumpPower)
        begin
          postLen <= cnt;
          flashEvt <= 1'b1;
          phase <= 2'h0;
        end
    endcase
  end
endmodule // fpet_flash_model
`default_nettype wire

// *** sim/fpet_flash_timing_props.sv ***
// port checks for the flash program and erase timer
`timescale 1ns/100ps
`default_nettype none
module fpet_flash_timing_props
(
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        dataArraySel,
  input wire logic        progArraySel,
  input wire logic        ispArraySel,
  input wire logic        pumpEnable,
  input wire logic        pumpPower,
  input wire logic        progPulse,
  input wire logic        erasePulse,
  input wire logic        addrLatch
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  // either high-voltage pulse
  wire anyPulse = progPulse | erasePulse;
  a_pulse_powered: assert property
    (anyPulse |-> pumpPower && !addrLatch)
    else $error("pulse without pump power");
  a_pulse_exclusive: assert property (!(progPulse && erasePulse))
    else $error("program and erase pulse together");
  a_one_array: assert property
    (pumpPower |-> $onehot({progArraySel, dataArraySel, ispArraySel}))
    else $error("array select not unique");
  // start and transition each take at least one cycle
  a_lead_phases: assert property
    ($rose(anyPulse) |-> $past(pumpPower) && $past(pumpPower, 2))
    else $error("pulse too soon after pump start");
  a_tail_phases: assert property
    ($fell(anyPulse) |-> pumpPower ##1 pumpPower)
    else $error("pump power dropped too soon");
  a_enable_hold: assert property
    ($fell(pumpPower) |-> pumpEnable ##1 !pumpEnable)
    else $error("pump enable hold wrong");
  a_addr_hold: assert property ($fell(pumpEnable) |-> !addrLatch[*2])
    else $error("address released too early");
  a_addr_busy: assert property (pumpEnable |-> !addrLatch)
    else $error("address free during operation");
  // bus answers stand until taken, and a write answer blocks new writes
  a_bresp_stands: assert property
    (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_stands: assert property
    (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped");
  a_busy_refuse: assert property
    (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
endmodule // fpet_flash_timing_props
bind fpet_flash_timing fpet_flash_timing_props u_props (
  .core_clk(core_clk), .sys_rst(sys_rst), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .dataArraySel(dataArraySel), .progArraySel(progArraySel),
  .ispArraySel(ispArraySel), .pumpEnable(pumpEnable), .pumpPower(pumpPower),
  .progPulse(progPulse), .erasePulse(erasePulse), .addrLatch(addrLatch));
`default_nettype wire

// *** sim/test_flash_program_erase_timing.sv ***
// self-checking bench for the flash program and erase timer
`timescale 1ns/100ps
`default_nettype none
`include "fpet_regs.vh"
module test_flash_program_erase_timing;
  typedef struct packed
  {
    logic [31:0] pre;
    logic [31:0] wid;
    logic [31:0] post;
    logic [1:0]  sel;
  } fpet_exp_t;
  logic core_clk = 0, sys_rst = 1;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdVal, preLen, pulseLen, postLen;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, flashEvt;
  logic [1:0] s_axi_bresp, s_axi_rresp, rdResp, selCode;
  logic progArraySel, dataArraySel, ispArraySel, pumpEnable, pumpPower;
  logic progPulse, erasePulse, addrLatch;
  fpet_exp_t expQ[$];      // expected phase lengths, oldest first
  fpet_exp_t obs;
  int unsigned cfg[2][6];  // per array: psc, start, tran, end, prog, erase
  int failCount = 0, compares = 0, k;
  always #5 core_clk = ~core_clk;
  fpet_flash_timing u_dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .progArraySel(progArraySel),
    .dataArraySel(dataArraySel), .ispArraySel(ispArraySel),
    .pumpEnable(pumpEnable), .pumpPower(pumpPower), .progPulse(progPulse),
    .erasePulse(erasePulse), .addrLatch(addrLatch));
  fpet_flash_model u_flash (.core_clk(core_clk), .pumpPower(pumpPower),
    .progPulse(progPulse), .erasePulse(erasePulse),
    .dataArraySel(dataArraySel), .ispArraySel(ispArraySel),
    .flashEvt(flashEvt), .preLen(preLen), .pulseLen(pulseLen),
    .postLen(postLen), .selCode(selCode));
  task automatic give_verdict;
    $display("compares %0d failCount %0d", compares, failCount);
    if (failCount == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp32(input logic [31:0] got, exp, input string what);
    compares++;
    if (got !== exp)
    begin
      failCount++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic hang(input string what);
    failCount++;
    $display("ERROR %0t %s timed out", $time, what);
    give_verdict;
  endtask
  // write one word; bready comes up after a random lag
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] st, input logic [1:0] er);
    int i, lag;
    lag = $urandom % 3;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (i = 0; i < 200; i++)
    begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bready && s_axi_bvalid)
      begin
        s_axi_bready <= 1'b0;
        cmp32({30'h0, s_axi_bresp}, {30'h0, er}, "bresp");
        return;
      end
      if (i >= lag)
        s_axi_bready <= 1'b1;
    end
    hang("write");
  endtask
  // read one word; rready comes up after a random lag
  task automatic axi_rd(input logic [7:0] a);
    int i, lag;
    lag = $urandom % 3;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (i = 0; i < 200; i++)
    begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rready && s_axi_rvalid)
      begin
        s_axi_rready <= 1'b0;
        rdVal = s_axi_rdata;
        rdResp = s_axi_rresp;
        return;
      end
      if (i >= lag)
        s_axi_rready <= 1'b1;
    end
    hang("read");
  endtask
  // write the timing and pulse words of one array
  task automatic wr_cfg(input int a);
    axi_wr(8'(a * 8), {cfg[a][3][7:0], cfg[a][2][7:0], cfg[a][1][7:0],
           cfg[a][0][7:0]}, 4'hF, `FPET_RESP_OKAY);
    axi_wr(8'(a * 8 + 4), {cfg[a][5][15:0], cfg[a][4][15:0]}, 4'hF,
           `FPET_RESP_OKAY);
  endtask
  // random counts for both register sets
  task automatic set_cfg;
    int a, f;
    for (a = 0; a < 2; a++)
    begin
      cfg[a][0] = $urandom % 4;
      for (f = 1; f < 6; f++)
        cfg[a][f] = 2 + $urandom % 5;
      wr_cfg(a);
    end
  endtask
  // one operation; a second start while busy must be ignored
  task automatic run_op(input logic [1:0] sel, input logic er);
    int i, u, a;
    fpet_exp_t e;
    a = (sel == `FPET_SEL_PROG) ? 0 : 1;
    u = cfg[a][0] + 1;
    e.pre = u * (cfg[a][1] + 1) + u * (cfg[a][2] + 1);
    e.wid = er ? u * 4 * (cfg[a][5] + 1) : u * (cfg[a][4] + 1);
    e.post = u * (cfg[a][2] + 1) + u * (cfg[a][3] + 1);
    e.sel = sel;
    expQ.push_back(e);
    axi_wr(`FPET_CONTROL_ADDR, {28'h0, sel, er, 1'b1}, 4'hF, `FPET_RESP_OKAY);
    axi_rd(`FPET_CONTROL_ADDR);
    cmp32(rdVal & 32'hF, {28'h0, sel, er, 1'b1}, "control");
    axi_wr(`FPET_CONTROL_ADDR, {28'h0, ~sel, ~er, 1'b1}, 4'hF,
           `FPET_RESP_OKAY);
    for (i = 0; i < 20000 && addrLatch !== 1'b1; i++)
      @(posedge core_clk);
    if (addrLatch !== 1'b1)
      hang("operation");
    repeat (2) @(posedge core_clk);
  endtask
  // compare each measured operation with the oldest expectation
  always @(posedge core_clk)
  begin
    if (flashEvt === 1'b1)
    begin
      if (expQ.size() == 0)
        cmp32(32'h1, 32'h0, "unexpected operation");
      else
      begin
        obs = expQ.pop_front();
        cmp32(preLen, obs.pre, "lead");
        cmp32(pulseLen, obs.wid, "pulse");
        cmp32(postLen, obs.post, "tail");
        cmp32({30'h0, selCode}, {30'h0, obs.sel}, "array");
      end
    end
  end
  initial
  begin
    void'($urandom(11517));
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    for (k = 0; k < 4; k++)
    begin
      axi_rd(8'(k * 4));
      cmp32(rdVal, `FPET_TIMING_RST, "reset value");
    end
    axi_rd(8'h18);
    cmp32(rdVal, 32'h0, "gap data");
    cmp32({30'h0, rdResp}, {30'h0, `FPET_RESP_SLVERR}, "gap resp");
    axi_wr(8'h18, 32'hFFFFFFFF, 4'hF, `FPET_RESP_SLVERR);
    axi_wr(`FPET_PROG_TIMING_ADDR, 32'hFFFFFFFF, 4'h2, `FPET_RESP_OKAY);
    axi_rd(`FPET_PROG_TIMING_ADDR);
    cmp32(rdVal, 32'h0000FF00, "strobe");
    // every array with both program and erase
    for (k = 0; k < 6; k++)
    begin
      set_cfg();
      run_op(2'(k / 2), k[0]);
    end
    // program array at in-limit timing: 35 us pulse, 1 ms erase setting
    cfg[0] = '{9, 99, 49, 49, 349, 2499};
    wr_cfg(0);
    run_op(`FPET_SEL_PROG, 1'b0);
    axi_rd(`FPET_STATUS_ADDR);
    cmp32({31'h0, rdVal[10]}, 32'h0, "early short flag");
    // erase then four bytes, far quicker than the minimum cycle
    run_op(`FPET_SEL_DATA, 1'b1);
    repeat (4) run_op(`FPET_SEL_DATA, 1'b0);
    axi_rd(`FPET_STATUS_ADDR);
    cmp32({31'h0, rdVal[10]}, 32'h1, "short reprogram");
    cmp32(expQ.size(), 32'h0, "missing operation");
    give_verdict;
  end
endmodule // test_flash_program_erase_timing
`default_nettype wire
